// File: core/lcao_defs.svh
`ifndef LCAO_DEFS_SVH
`define LCAO_DEFS_SVH

`define LCAO_OFS_PROG_PERM 8'h00
`define LCAO_OFS_TGT_PERM  8'h04
`define LCAO_OFS_FGEN_PERM 8'h08
`define LCAO_OFS_BTN_DEST  8'h0c
`define LCAO_OFS_SEC_CODE  8'h10
`define LCAO_OFS_LOCKOUT   8'h14
`define LCAO_OFS_NET_ADDR  8'h18
`define LCAO_OFS_BAUD      8'h1c
`define LCAO_OFS_ROUTE     8'h20
`define LCAO_OFS_SRC_TYPE  8'h24
`define LCAO_OFS_ANA_MIN   8'h28
`define LCAO_OFS_ANA_MAX   8'h2c
`define LCAO_OFS_SENSE     8'h30
`define LCAO_OFS_OUT_SEL   8'h34
`define LCAO_OFS_OUT_INV   8'h38
`define LCAO_OFS_UNLOCK    8'h3c
`define LCAO_OFS_ACTIVE    8'h40

`define LCAO_PERM_LOCKED 2'h0
`define LCAO_PERM_FULL   2'h1
`define LCAO_PERM_CODE   2'h2
`define LCAO_BTN_TARGET  2'h1
`define LCAO_BTN_NONE    2'h0
`define LCAO_SRC_POT     2'h1
`define LCAO_BAUD_DEF    3'h1
`define LCAO_ROUTE_NONE  3'h0
`define LCAO_NUM_ZERO    14'h0000
`define LCAO_LOCKOUT_DEF 5'h1f
`define LCAO_ADDR_DEF    7'h01
`define LCAO_ADDR_OFF    7'h00
`define LCAO_SENSE_NO    1'h0
`define LCAO_SW_DEF      8'h00

`define LCAO_MAX_PERM  32'h00000002
`define LCAO_MIN_ONE   32'h00000001
`define LCAO_MIN_ZERO  32'h00000000
`define LCAO_MAX_BTN   32'h00000003
`define LCAO_MAX_NUM   32'h0000270f
`define LCAO_MAX_LOCK  32'h0000001f
`define LCAO_MAX_ADDR  32'h00000063
`define LCAO_MAX_BAUD  32'h00000005
`define LCAO_MAX_ROUTE 32'h00000006
`define LCAO_MAX_SRC   32'h00000003
`define LCAO_MAX_SENSE 32'h00000001
`define LCAO_MAX_SW    32'h000000ff

`define LCAO_RATE_1 32'h0000012c
`define LCAO_RATE_2 32'h000004b0
`define LCAO_RATE_3 32'h00000960
`define LCAO_RATE_4 32'h000012c0
`define LCAO_RATE_5 32'h00002580
`define LCAO_CLK_HZ 200000000

`endif

// File: core/lcao_pkg.sv
package lcao_pkg;
  typedef logic [1:0]  lcao_perm_t;
  typedef logic [13:0] lcao_num_t;
  typedef logic [2:0]  lcao_baud_t;
  typedef logic [19:0] lcao_div_t;
endpackage

// File: core/lcao_baud_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcao_defs.svh"
module lcao_baud_tick #(
  parameter int CLK_HZ = `LCAO_CLK_HZ
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire lcao_pkg::lcao_baud_t baud_code,
  output logic                    baud_tick
);
  lcao_pkg::lcao_div_t count;
  lcao_pkg::lcao_div_t next_count;
  lcao_pkg::lcao_div_t limit;
  logic                next_tick;

  function automatic lcao_pkg::lcao_div_t div_of(input lcao_pkg::lcao_baud_t c);
    int unsigned rate;
    case (c)
      3'h2:    rate = `LCAO_RATE_2;
      3'h3:    rate = `LCAO_RATE_3;
      3'h4:    rate = `LCAO_RATE_4;
      3'h5:    rate = `LCAO_RATE_5;
      default: rate = `LCAO_RATE_1;
    endcase
    return lcao_pkg::lcao_div_t'(CLK_HZ / rate - 1);
  endfunction

  always_comb begin
    limit      = div_of(baud_code);
    next_tick  = 1'b0;
    next_count = count + 20'h00001;
    if (count >= limit) begin
      next_count = 20'h00000;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count     <= 20'h00000;
      baud_tick <= 1'b0;
    end else begin
      count     <= next_count;
      baud_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// File: core/lcao_config_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcao_defs.svh"
module lcao_config_bank #(
  parameter int CLK_HZ = `LCAO_CLK_HZ
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               restart,
  input  wire logic [1:0]         menu_dest_override,
  input  wire logic               rx_valid,
  input  wire logic [6:0]         rx_addr,
  input  wire logic [7:0]         out_cond,
  output logic                    rx_accept,
  output logic                    prog_change_ok,
  output logic                    target_change_ok,
  output logic                    fgen_change_ok,
  output logic [1:0]              button_dest,
  output logic [4:0]              menu_enable,
  output logic [6:0]              net_addr,
  output lcao_pkg::lcao_baud_t    baud_code,
  output logic                    baud_tick,
  output logic [2:0]              ana_route,
  output logic [1:0]              ana_src_type,
  output lcao_pkg::lcao_num_t     ana_min,
  output lcao_pkg::lcao_num_t     ana_max,
  output logic                    user_out
);
  lcao_pkg::lcao_perm_t prog_stage, tgt_stage, fgen_stage;
  lcao_pkg::lcao_perm_t prog_perm, tgt_perm, fgen_perm;
  lcao_pkg::lcao_perm_t next_prog_stage, next_tgt_stage, next_fgen_stage;
  lcao_pkg::lcao_perm_t next_prog_perm, next_tgt_perm, next_fgen_perm;
  lcao_pkg::lcao_baud_t baud_stage, next_baud_stage, next_baud_code;
  lcao_pkg::lcao_num_t  sec_code, next_sec_code;
  lcao_pkg::lcao_num_t  next_ana_min, next_ana_max;
  logic [1:0]           btn_default, next_btn_default;
  logic [4:0]           next_menu_enable;
  logic [6:0]           next_net_addr;
  logic [2:0]           next_ana_route;
  logic [1:0]           next_ana_src_type;
  logic                 sense, next_sense;
  logic [7:0]           out_sel, next_out_sel;
  logic [7:0]           out_inv, next_out_inv;
  logic [7:0]           cond_term;
  logic                 unlocked, next_unlocked;
  logic                 next_user_out;
  logic [31:0]          next_prdata;
  logic                 mapped;
  logic                 legal;
  logic                 access;
  logic                 wr;
  logic                 code_match;

  function automatic logic fits(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic perm_ok(input lcao_pkg::lcao_perm_t p, input lcao_pkg::lcao_num_t code,
                                   input logic unl);
    return (p == `LCAO_PERM_FULL) ||
           ((p == `LCAO_PERM_CODE) && ((code == `LCAO_NUM_ZERO) || unl));
  endfunction

  assign pready = 1'b1;
  assign access = psel && penable;
  assign wr     = access && pwrite;
  assign pslverr = access && (!mapped || (pwrite && !legal));
  assign code_match = (sec_code != `LCAO_NUM_ZERO) && (pwdata == {18'h00000, sec_code});

  // Address decode and value range check for writes
  always_comb begin
    mapped = 1'b1;
    legal  = 1'b1;
    case (paddr)
      `LCAO_OFS_PROG_PERM,
      `LCAO_OFS_TGT_PERM,
      `LCAO_OFS_FGEN_PERM: legal = fits(pwdata, `LCAO_MIN_ZERO, `LCAO_MAX_PERM);
      `LCAO_OFS_BTN_DEST:  legal = fits(pwdata, `LCAO_MIN_ONE, `LCAO_MAX_BTN);
      `LCAO_OFS_SEC_CODE,
      `LCAO_OFS_ANA_MIN,
      `LCAO_OFS_ANA_MAX:   legal = fits(pwdata, `LCAO_MIN_ZERO, `LCAO_MAX_NUM);
      `LCAO_OFS_LOCKOUT:   legal = fits(pwdata, `LCAO_MIN_ZERO, `LCAO_MAX_LOCK);
      `LCAO_OFS_NET_ADDR:  legal = fits(pwdata, `LCAO_MIN_ZERO, `LCAO_MAX_ADDR);
      `LCAO_OFS_BAUD:      legal = fits(pwdata, `LCAO_MIN_ONE, `LCAO_MAX_BAUD);
      `LCAO_OFS_ROUTE:     legal = fits(pwdata, `LCAO_MIN_ZERO, `LCAO_MAX_ROUTE);
      `LCAO_OFS_SRC_TYPE:  legal = fits(pwdata, `LCAO_MIN_ONE, `LCAO_MAX_SRC);
      `LCAO_OFS_SENSE:     legal = fits(pwdata, `LCAO_MIN_ZERO, `LCAO_MAX_SENSE);
      `LCAO_OFS_OUT_SEL,
      `LCAO_OFS_OUT_INV:   legal = fits(pwdata, `LCAO_MIN_ZERO, `LCAO_MAX_SW);
      `LCAO_OFS_UNLOCK:    legal = 1'b1;
      `LCAO_OFS_ACTIVE:    legal = 1'b0;
      default: begin
        mapped = 1'b0;
        legal  = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_prog_stage   = prog_stage;
    next_tgt_stage    = tgt_stage;
    next_fgen_stage   = fgen_stage;
    next_prog_perm    = prog_perm;
    next_tgt_perm     = tgt_perm;
    next_fgen_perm    = fgen_perm;
    next_baud_stage   = baud_stage;
    next_baud_code    = baud_code;
    next_btn_default  = btn_default;
    next_sec_code     = sec_code;
    next_menu_enable  = menu_enable;
    next_net_addr     = net_addr;
    next_ana_route    = ana_route;
    next_ana_src_type = ana_src_type;
    next_ana_min      = ana_min;
    next_ana_max      = ana_max;
    next_sense        = sense;
    next_out_sel      = out_sel;
    next_out_inv      = out_inv;
    next_unlocked     = unlocked;
    if (wr && legal) begin
      case (paddr)
        `LCAO_OFS_PROG_PERM: next_prog_stage = pwdata[1:0];
        `LCAO_OFS_TGT_PERM:  next_tgt_stage = pwdata[1:0];
        `LCAO_OFS_FGEN_PERM: next_fgen_stage = pwdata[1:0];
        `LCAO_OFS_BTN_DEST:  next_btn_default = pwdata[1:0];
        `LCAO_OFS_SEC_CODE:  next_sec_code = pwdata[13:0];
        `LCAO_OFS_LOCKOUT:   next_menu_enable = pwdata[4:0];
        `LCAO_OFS_NET_ADDR:  next_net_addr = pwdata[6:0];
        `LCAO_OFS_BAUD:      next_baud_stage = pwdata[2:0];
        `LCAO_OFS_ROUTE:     next_ana_route = pwdata[2:0];
        `LCAO_OFS_SRC_TYPE:  next_ana_src_type = pwdata[1:0];
        `LCAO_OFS_ANA_MIN:   next_ana_min = pwdata[13:0];
        `LCAO_OFS_ANA_MAX:   next_ana_max = pwdata[13:0];
        `LCAO_OFS_SENSE:     next_sense = pwdata[0];
        `LCAO_OFS_OUT_SEL:   next_out_sel = pwdata[7:0];
        `LCAO_OFS_OUT_INV:   next_out_inv = pwdata[7:0];
        default: begin
        end
      endcase
    end
    // Staged settings become active only at a restart
    if (restart) begin
      next_prog_perm = prog_stage;
      next_tgt_perm  = tgt_stage;
      next_fgen_perm = fgen_stage;
      next_baud_code = baud_stage;
    end
    // A new code or a restart drops the unlock; a correct entry wins
    if (restart || (wr && legal && (paddr == `LCAO_OFS_SEC_CODE))) begin
      next_unlocked = 1'b0;
    end
    if (wr && (paddr == `LCAO_OFS_UNLOCK) && code_match) begin
      next_unlocked = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_stage   <= `LCAO_PERM_FULL;
      tgt_stage    <= `LCAO_PERM_FULL;
      fgen_stage   <= `LCAO_PERM_FULL;
      prog_perm    <= `LCAO_PERM_FULL;
      tgt_perm     <= `LCAO_PERM_FULL;
      fgen_perm    <= `LCAO_PERM_FULL;
      baud_stage   <= `LCAO_BAUD_DEF;
      baud_code    <= `LCAO_BAUD_DEF;
      btn_default  <= `LCAO_BTN_TARGET;
      sec_code     <= `LCAO_NUM_ZERO;
      menu_enable  <= `LCAO_LOCKOUT_DEF;
      net_addr     <= `LCAO_ADDR_DEF;
      ana_route    <= `LCAO_ROUTE_NONE;
      ana_src_type <= `LCAO_SRC_POT;
      ana_min      <= `LCAO_NUM_ZERO;
      ana_max      <= `LCAO_NUM_ZERO;
      sense        <= `LCAO_SENSE_NO;
      out_sel      <= `LCAO_SW_DEF;
      out_inv      <= `LCAO_SW_DEF;
      unlocked     <= 1'b0;
    end else begin
      prog_stage   <= next_prog_stage;
      tgt_stage    <= next_tgt_stage;
      fgen_stage   <= next_fgen_stage;
      prog_perm    <= next_prog_perm;
      tgt_perm     <= next_tgt_perm;
      fgen_perm    <= next_fgen_perm;
      baud_stage   <= next_baud_stage;
      baud_code    <= next_baud_code;
      btn_default  <= next_btn_default;
      sec_code     <= next_sec_code;
      menu_enable  <= next_menu_enable;
      net_addr     <= next_net_addr;
      ana_route    <= next_ana_route;
      ana_src_type <= next_ana_src_type;
      ana_min      <= next_ana_min;
      ana_max      <= next_ana_max;
      sense        <= next_sense;
      out_sel      <= next_out_sel;
      out_inv      <= next_out_inv;
      unlocked     <= next_unlocked;
    end
  end

  // Read data is captured in the setup cycle so it stands through the access
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `LCAO_OFS_PROG_PERM: next_prdata = {30'h00000000, prog_stage};
        `LCAO_OFS_TGT_PERM:  next_prdata = {30'h00000000, tgt_stage};
        `LCAO_OFS_FGEN_PERM: next_prdata = {30'h00000000, fgen_stage};
        `LCAO_OFS_BTN_DEST:  next_prdata = {30'h00000000, btn_default};
        `LCAO_OFS_SEC_CODE:  next_prdata = {18'h00000, sec_code};
        `LCAO_OFS_LOCKOUT:   next_prdata = {27'h0000000, menu_enable};
        `LCAO_OFS_NET_ADDR:  next_prdata = {25'h0000000, net_addr};
        `LCAO_OFS_BAUD:      next_prdata = {29'h00000000, baud_stage};
        `LCAO_OFS_ROUTE:     next_prdata = {29'h00000000, ana_route};
        `LCAO_OFS_SRC_TYPE:  next_prdata = {30'h00000000, ana_src_type};
        `LCAO_OFS_ANA_MIN:   next_prdata = {18'h00000, ana_min};
        `LCAO_OFS_ANA_MAX:   next_prdata = {18'h00000, ana_max};
        `LCAO_OFS_SENSE:     next_prdata = {31'h00000000, sense};
        `LCAO_OFS_OUT_SEL:   next_prdata = {24'h000000, out_sel};
        `LCAO_OFS_OUT_INV:   next_prdata = {24'h000000, out_inv};
        `LCAO_OFS_ACTIVE:    next_prdata = {22'h000000, unlocked, baud_code,
                                            fgen_perm, tgt_perm, prog_perm};
        default:             next_prdata = 32'h00000000;
      endcase
    end
  end

  // Each selected condition, optionally inverted, feeds an OR
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cond
      assign cond_term[gi] = out_sel[gi] && (out_cond[gi] ^ out_inv[gi]);
    end
  endgenerate

  assign next_user_out = (|cond_term) ^ sense;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata   <= 32'h00000000;
      user_out <= `LCAO_SENSE_NO;
    end else begin
      prdata   <= next_prdata;
      user_out <= next_user_out;
    end
  end

  assign prog_change_ok   = perm_ok(prog_perm, sec_code, unlocked);
  assign target_change_ok = perm_ok(tgt_perm, sec_code, unlocked);
  assign fgen_change_ok   = perm_ok(fgen_perm, sec_code, unlocked);
  assign button_dest = (menu_dest_override != `LCAO_BTN_NONE) ? menu_dest_override : btn_default;
  assign rx_accept = rx_valid && (net_addr != `LCAO_ADDR_OFF) && (rx_addr == net_addr);

  lcao_baud_tick #(
    .CLK_HZ (CLK_HZ)
  ) u_baud (
    .pclk      (pclk),
    .presetn   (presetn),
    .baud_code (baud_code),
    .baud_tick (baud_tick)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_unlock_write;
    wr && (paddr == `LCAO_OFS_UNLOCK) && code_match;
  endsequence

  sequence s_code_write;
    wr && legal && (paddr == `LCAO_OFS_SEC_CODE);
  endsequence

  sequence s_lockout_write;
    wr && legal && (paddr == `LCAO_OFS_LOCKOUT);
  endsequence

  a_perm_waits_restart: assert property (
    !restart |=> (prog_perm == $past(prog_perm)) && (tgt_perm == $past(tgt_perm)))
    else $error("active permission changed without restart");

  a_restart_applies: assert property (
    restart |=> (fgen_perm == $past(fgen_stage)) && (baud_code == $past(baud_stage)))
    else $error("restart did not apply staged settings");

  a_locked_denies: assert property (
    (tgt_perm == `LCAO_PERM_LOCKED) |-> !target_change_ok)
    else $error("locked permission allowed a change");

  a_code_gate_holds: assert property (
    (prog_perm == `LCAO_PERM_CODE) && (sec_code != `LCAO_NUM_ZERO) && !unlocked |-> !prog_change_ok)
    else $error("code gated change allowed without entry");

  a_unlock_grants: assert property (
    s_unlock_write ##1 !restart |-> unlocked)
    else $error("correct code entry did not unlock");

  a_zero_code_open: assert property (
    (fgen_perm == `LCAO_PERM_CODE) && (sec_code == `LCAO_NUM_ZERO) |-> fgen_change_ok)
    else $error("zero code did not bypass the check");

  a_addr_zero_deaf: assert property (
    (net_addr == `LCAO_ADDR_OFF) |-> !rx_accept)
    else $error("message accepted at address zero");

  a_ranges_kept: assert property (
    (ana_min <= 14'h270f) && (ana_max <= 14'h270f) && (net_addr <= 7'h63) && (ana_route <= 3'h6))
    else $error("stored value out of range");

  a_baud_legal: assert property (
    (baud_stage >= 3'h1) && (baud_stage <= 3'h5) && (baud_code >= 3'h1) && (baud_code <= 3'h5))
    else $error("baud code out of range");

  a_user_out_logic: assert property (
    1'b1 |=> user_out == ((|($past(out_sel) & ($past(out_cond) ^ $past(out_inv)))) ^ $past(sense)))
    else $error("user output does not follow its inputs");

  a_unmapped_error: assert property (
    access && (paddr > `LCAO_OFS_ACTIVE) |-> pslverr)
    else $error("unmapped access not flagged");

  a_code_stored: assert property (
    s_code_write |=> (sec_code == $past(pwdata[13:0])) && !unlocked)
    else $error("security code write not stored");

  a_lockout_stored: assert property (
    s_lockout_write |=> (menu_enable == $past(pwdata[4:0])))
    else $error("lockout switch write not stored");

  a_refused_write: assert property (
    wr && !legal |=> (sec_code == $past(sec_code)) && (net_addr == $past(net_addr)) &&
                     (menu_enable == $past(menu_enable)))
    else $error("refused write changed a setting");

  a_relock_restart: assert property (
    restart && !(wr && (paddr == `LCAO_OFS_UNLOCK)) |=> !unlocked)
    else $error("restart left the code entry unlocked");

  a_override_wins: assert property (
    (menu_dest_override != `LCAO_BTN_NONE) |-> (button_dest == menu_dest_override))
    else $error("set menu override ignored");
endmodule
`default_nettype wire

// File: bench/lcao_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcao_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       en,
  input  wire logic [6:0] near,
  output logic            rx_valid,
  output logic [6:0]      rx_addr,
  output logic [7:0]      out_cond
);
  // Half of the messages aim at this node so both filter outcomes occur
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid <= 1'b0;
      rx_addr  <= 7'h00;
      out_cond <= 8'h00;
    end else if (en) begin
      rx_valid <= 1'($urandom);
      rx_addr  <= ($urandom % 2) ? near : 7'($urandom);
      out_cond <= 8'($urandom);
    end else begin
      // Idle line drops valid; the address is inverted every cycle
      rx_valid <= 1'b0;
      rx_addr  <= ~rx_addr;
    end
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcao_defs.svh"
module testbench;
  localparam int CLK = 96000;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic                 restart = 1'b0;
  logic [1:0]           menu_dest_override = 2'h0;
  logic                 hen = 1'b0;
  logic                 rx_valid, pready, pslverr, rx_accept, baud_tick, user_out;
  logic [6:0]           rx_addr, net_addr;
  logic [7:0]           out_cond;
  logic [31:0]          prdata;
  logic                 prog_ok, tgt_ok, fgen_ok;
  logic [1:0]           button_dest, ana_src_type;
  logic [4:0]           menu_enable;
  lcao_pkg::lcao_baud_t baud_code;
  logic [2:0]           ana_route;
  lcao_pkg::lcao_num_t  ana_min, ana_max;
  logic                 mon = 1'b0;
  logic [6:0]           m_addr = 7'h01;
  logic [7:0]           m_sel = 8'h00;
  logic [7:0]           m_inv = 8'h00;
  logic                 m_sense = 1'b0;
  logic                 exp_uo = 1'b0;
  int                   n_fail = 0;
  int                   compares = 0;
  int                   cyc = 0;
  int mx[15] = '{2, 2, 2, 3, 9999, 31, 99, 5, 6, 3, 9999, 9999, 1, 255, 255};
  int mn[15] = '{0, 0, 0, 1, 0, 0, 0, 1, 0, 1, 0, 0, 0, 0, 0};
  int df[15] = '{1, 1, 1, 1, 0, 31, 1, 1, 0, 1, 0, 0, 0, 0, 0};
  int rt[5]  = '{300, 1200, 2400, 4800, 9600};

  always #2.5 pclk = ~pclk;

  lcao_config_bank #(.CLK_HZ(CLK)) i_lcao_config_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .restart(restart), .menu_dest_override(menu_dest_override), .rx_valid(rx_valid),
    .rx_addr(rx_addr), .out_cond(out_cond), .rx_accept(rx_accept), .prog_change_ok(prog_ok),
    .target_change_ok(tgt_ok), .fgen_change_ok(fgen_ok), .button_dest(button_dest),
    .menu_enable(menu_enable), .net_addr(net_addr), .baud_code(baud_code), .baud_tick(baud_tick),
    .ana_route(ana_route), .ana_src_type(ana_src_type), .ana_min(ana_min), .ana_max(ana_max),
    .user_out(user_out));

  lcao_host_model i_lcao_host_model (.pclk(pclk), .presetn(presetn), .en(hen), .near(m_addr),
    .rx_valid(rx_valid), .rx_addr(rx_addr), .out_cond(out_cond));

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Let the registers take the write before the caller looks at them
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk_bit("pslverr", ee, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_val("prdata", x, r);
    chk_bit("pslverr", ee, e);
  endtask

  task automatic pulse_restart();
    @(posedge pclk);
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk_ok(input logic e);
    chk_bit("prog_ok", e, prog_ok);
    chk_bit("tgt_ok", e, tgt_ok);
    chk_bit("fgen_ok", e, fgen_ok);
  endtask

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    if (mon) begin
      chk_bit("user_out", exp_uo, user_out);
      chk_bit("rx_accept", rx_valid && m_addr != 7'h00 && rx_addr == m_addr, rx_accept);
    end
    exp_uo = (|(m_sel & (out_cond ^ m_inv))) ^ m_sense;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    logic [7:0]  a;
    logic [31:0] v;
    logic [31:0] code;
    int          n;
    presetn <= 1'b0;
    void'($urandom(32'h150d1b61));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 15; i++) rd(8'(i * 4), df[i], 1'b0);
    rd(`LCAO_OFS_ACTIVE, 32'h55, 1'b0);
    chk_val("menu_enable", 32'h1f, 32'(menu_enable));
    chk_val("net_addr", 32'h1, 32'(net_addr));
    chk_val("ana_src_type", 32'h1, 32'(ana_src_type));
    for (int i = 0; i < 15; i++) begin
      a = 8'(i * 4);
      wr(a, mx[i], 1'b0);
      rd(a, mx[i], 1'b0);
      wr(a, mx[i] + 1, 1'b1);
      rd(a, mx[i], 1'b0);
      if (mn[i] == 1) wr(a, 32'h0, 1'b1);
      v = mn[i] + $urandom % (mx[i] - mn[i] + 1);
      wr(a, v, 1'b0);
      rd(a, v, 1'b0);
      case (i)
        5:  chk_val("menu_enable", v, 32'(menu_enable));
        6:  chk_val("net_addr", v, 32'(net_addr));
        9:  chk_val("ana_src_type", v, 32'(ana_src_type));
        10: chk_val("ana_min", v, 32'(ana_min));
        11: chk_val("ana_max", v, 32'(ana_max));
        default: ;
      endcase
      wr(a, df[i], 1'b0);
    end
    rd(8'h44, 32'h0, 1'b1);
    wr(`LCAO_OFS_ACTIVE, 32'h0, 1'b1);
    rd(`LCAO_OFS_UNLOCK, 32'h0, 1'b0);
    for (int p = 0; p < 3; p++) begin
      wr(`LCAO_OFS_PROG_PERM, p, 1'b0);
      wr(`LCAO_OFS_TGT_PERM, p, 1'b0);
      wr(`LCAO_OFS_FGEN_PERM, p, 1'b0);
      chk_ok(p != 1);
      pulse_restart();
      chk_ok(p != 0);
      rd(`LCAO_OFS_ACTIVE, 32'(p | p << 2 | p << 4 | 64), 1'b0);
    end
    code = 1 + $urandom % 9999;
    wr(`LCAO_OFS_SEC_CODE, code, 1'b0);
    chk_ok(1'b0);
    wr(`LCAO_OFS_UNLOCK, code + 1, 1'b0);
    chk_ok(1'b0);
    wr(`LCAO_OFS_UNLOCK, code, 1'b0);
    chk_ok(1'b1);
    rd(`LCAO_OFS_ACTIVE, 32'h26a, 1'b0);
    pulse_restart();
    chk_ok(1'b0);
    wr(`LCAO_OFS_SEC_CODE, 32'h0, 1'b0);
    chk_ok(1'b1);
    wr(`LCAO_OFS_BTN_DEST, 32'h2, 1'b0);
    for (int ov = 0; ov < 4; ov++) begin
      menu_dest_override <= 2'(ov);
      repeat (2) @(posedge pclk);
      chk_val("button_dest", (ov != 0) ? ov : 2, 32'(button_dest));
    end
    for (int k = 1; k < 6; k++) begin
      wr(`LCAO_OFS_BAUD, k, 1'b0);
      chk_val("baud_code", (k == 1) ? 1 : k - 1, 32'(baud_code));
      pulse_restart();
      chk_val("baud_code", k, 32'(baud_code));
      while (baud_tick !== 1'b1) @(posedge pclk);
      @(posedge pclk);
      n = 1;
      while (baud_tick !== 1'b1) begin
        @(posedge pclk);
        n++;
      end
      chk_val("baud_period", CLK / rt[k - 1], n);
    end
    for (int k = 0; k < 3; k++) begin
      mon = 1'b0;
      m_addr = (k == 0) ? 7'h00 : 7'(1 + $urandom % 99);
      m_sel = 8'($urandom);
      m_inv = 8'($urandom);
      m_sense = 1'($urandom);
      v = $urandom % 7;
      wr(`LCAO_OFS_NET_ADDR, m_addr, 1'b0);
      wr(`LCAO_OFS_OUT_SEL, m_sel, 1'b0);
      wr(`LCAO_OFS_OUT_INV, m_inv, 1'b0);
      wr(`LCAO_OFS_SENSE, m_sense, 1'b0);
      wr(`LCAO_OFS_ROUTE, v, 1'b0);
      chk_val("ana_route", v, 32'(ana_route));
      hen <= 1'b1;
      repeat (2) @(posedge pclk);
      mon = 1'b1;
      repeat (200) @(posedge pclk);
    end
    mon = 1'b0;
    end_of_test();
  end
endmodule
`default_nettype wire
